// ==== drs_pkg.sv ====
// Shared constants, types and helpers for the run/stop and power sequencing block
package drs_pkg;
    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int INIT_TIME_MS = 200;
    localparam int INIT_CYC = INIT_TIME_MS * (CLK_HZ / 1000);
    localparam int LOSS_TIME_MS = 15;
    localparam int LOSS_CYC = LOSS_TIME_MS * (CLK_HZ / 1000);
    localparam int LONG_TIME_MS = 100;
    localparam int LONG_CYC = LONG_TIME_MS * (CLK_HZ / 1000);
    localparam int BRAKE_UNIT_MS = 100;
    localparam int BRAKE_UNIT_CYC = BRAKE_UNIT_MS * (CLK_HZ / 1000);
    localparam int DEB_TIME_US = 1000;
    localparam int DEB_CYC = DEB_TIME_US * (CLK_HZ / 1_000_000);
    localparam int RAMP_UNIT_US = 1;
    localparam int RAMP_UNIT_CYC = RAMP_UNIT_US * (CLK_HZ / 1_000_000);

    // ----------------------------------------------------------------
    // Widths and field layout
    // ----------------------------------------------------------------
    localparam int SPEED_W = 16;
    localparam int CNT_W = 40;
    localparam int N_ASSIGN = 3;
    localparam int FN_W = 4;
    localparam int MAP_W = N_ASSIGN * FN_W;
    localparam int IN_FWD = 0;
    localparam int IN_REV = 1;
    localparam int IN_SHUT = 2;
    localparam int IN_ASG = 3;
    localparam int IN_W = IN_ASG + N_ASSIGN;

    // Function codes of the assignable inputs
    localparam logic [FN_W-1:0] FN_JOG = 4'h3;
    localparam logic [FN_W-1:0] FN_SHUTOFF = 4'h5;
    localparam logic [FN_W-1:0] FN_HOLD = 4'h6;

    // Restart coasting setting, 0.1 s units; 0 to 5.0 s enables restart
    localparam logic [15:0] RESTART_MAX = 16'h0032;

    typedef enum logic [2:0] {
        ST_INIT = 3'b000,
        ST_IDLE = 3'b001,
        ST_RUN = 3'b011,
        ST_DECEL = 3'b010,
        ST_BRAKE = 3'b110,
        ST_OFF = 3'b111
    } drs_state_type;

    typedef enum logic [1:0] {
        LATCH_NONE = 2'h0,
        LATCH_FWD = 2'h1,
        LATCH_REV = 2'h2
    } drs_latch_type;

    // True when any assignable input mapped to code is closed
    function automatic logic drs_fn_closed(input logic [MAP_W-1:0] map,
                                           input logic [N_ASSIGN-1:0] pins,
                                           input logic [FN_W-1:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < N_ASSIGN; i++) begin
            if (map[i*FN_W +: FN_W] == code && pins[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction
endpackage

// ==== drs_debounce.sv ====
// Two-flop synchroniser and stability filter for the contact inputs
`timescale 1ns/1ps
module drs_debounce
    import drs_pkg::*;
#(
    parameter int W = IN_W,
    parameter int CYCLES = DEB_CYC
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [W-1:0] raw,
    output logic [W-1:0] clean
);
    logic [W-1:0] sync1;
    logic [W-1:0] sync2;
    logic [W-1:0] cand;
    logic [31:0] cnt;
    logic [W-1:0] next_cand;
    logic [31:0] next_cnt;
    logic [W-1:0] next_clean;

    // A level is accepted only after it held for the whole window
    always_comb begin
        next_cand = cand;
        next_cnt = cnt;
        next_clean = clean;
        if (sync2 != cand) begin
            next_cand = sync2;
            next_cnt = 32'h0;
        end else if (cnt >= 32'(CYCLES - 1)) begin
            next_clean = cand;
        end else begin
            next_cnt = cnt + 32'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            sync1 <= '0;
            sync2 <= '0;
            cand <= '0;
            cnt <= 32'h0;
            clean <= '0;
        end else begin
            sync1 <= raw;
            sync2 <= sync1;
            cand <= next_cand;
            cnt <= next_cnt;
            clean <= next_clean;
        end
    end
endmodule

// ==== drs_timer.sv ====
// Loadable down-counter with a registered expiry level
`timescale 1ns/1ps
module drs_timer
    import drs_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic load,
    input wire logic [CNT_W-1:0] value,
    output logic done
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic next_done;

    always_comb begin
        if (load) begin
            next_count = value;
        end else if (count != '0) begin
            next_count = count - CNT_W'(1);
        end else begin
            next_count = count;
        end
        next_done = !load && (next_count == '0);
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            count <= '0;
            done <= 1'b0;
        end else begin
            count <= next_count;
            done <= next_done;
        end
    end
endmodule

// ==== drs_run_stop.sv ====
// Run/stop command, start latch and power sequencing of the drive
//
// Notes on behaviour
// - Start waits out 0.2 s initial reset.
// - Supply lost over 15 ms shuts output.
// - Outage of 100 ms clears protective trip.
// - 15-100 ms outage raises power-fail alarm.
// - Restart setting 0..5 s: restart, no alarm.
// - Long outage restarts if start still on.
// - Outside jog, with zero minimum speed, run only when setpoint reaches start speed.
// - Nonzero minimum speed: start alone ramps there.
// - Stop applies DC brake at or below brake speed.
// - Zero brake time skips DC braking.
// - Two-wire: direction input runs and stops.
// - Two-wire: both inputs or release stops.
// - Hold assigned to an input selects three-wire mode.
// - Three-wire: momentary start is latched.
// - Three-wire: last direction input wins.
// - Three-wire: opposite input reverses directly.
// - Three-wire: opening hold clears, decelerates.
// - Jog closed ignores hold, jog first.
// - Output shutoff resets the start latch.
// - Hold only via assignable input mapping.
// - Contactor off over 0.1 s: full reset.
// - Output shutoff cuts the output at once.
`timescale 1ns/1ps
module drs_run_stop
    import drs_pkg::*;
#(
    parameter int INIT_CYCLES = INIT_CYC,
    parameter int LOSS_CYCLES = LOSS_CYC,
    parameter int LONG_CYCLES = LONG_CYC,
    parameter int BRAKE_UNIT_CYCLES = BRAKE_UNIT_CYC,
    parameter int DEBOUNCE_CYCLES = DEB_CYC
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic forward_start_input,
    input wire logic reverse_start_input,
    input wire logic output_shutoff_input,
    input wire logic [N_ASSIGN-1:0] assignable_input,
    input wire logic supply_ok,
    input wire logic [SPEED_W-1:0] speed_setpoint,
    input wire logic [SPEED_W-1:0] start_speed_param,
    input wire logic [SPEED_W-1:0] min_speed_param,
    input wire logic [SPEED_W-1:0] jog_speed_param,
    input wire logic [15:0] accel_time_param,
    input wire logic [SPEED_W-1:0] brake_speed_param,
    input wire logic [15:0] brake_time_param,
    input wire logic [15:0] restart_coast_param,
    input wire logic [MAP_W-1:0] terminal_assign_param,
    output logic output_enable,
    output logic reverse_polarity,
    output logic [SPEED_W-1:0] speed_command,
    output logic dc_brake_active,
    output logic power_fail_alarm,
    output logic three_wire_active
);
    // ----------------------------------------------------------------
    // Contact inputs
    // ----------------------------------------------------------------
    logic [IN_W-1:0] raw_in;
    logic [IN_W-1:0] deb_in;
    logic fwd_q;
    logic rev_q;
    logic shut_q;
    logic jog_q;
    logic hold_closed;
    logic hold_assigned;
    logic three_wire;
    logic fwd_prev;
    logic rev_prev;
    logic fwd_rise;
    logic rev_rise;

    assign raw_in = {assignable_input, output_shutoff_input, reverse_start_input,
                     forward_start_input};

    drs_debounce #(.W(IN_W), .CYCLES(DEBOUNCE_CYCLES)) u_debounce (
        .clock(clock),
        .rstn(rstn),
        .raw(raw_in),
        .clean(deb_in)
    );

    assign fwd_q = deb_in[IN_FWD];
    assign rev_q = deb_in[IN_REV];
    assign jog_q = drs_fn_closed(terminal_assign_param, deb_in[IN_ASG +: N_ASSIGN], FN_JOG);
    assign shut_q = deb_in[IN_SHUT] ||
        drs_fn_closed(terminal_assign_param, deb_in[IN_ASG +: N_ASSIGN], FN_SHUTOFF);
    assign hold_closed =
        drs_fn_closed(terminal_assign_param, deb_in[IN_ASG +: N_ASSIGN], FN_HOLD);
    assign hold_assigned = drs_fn_closed(terminal_assign_param, {N_ASSIGN{1'b1}}, FN_HOLD);
    assign three_wire = hold_assigned && !jog_q;
    assign fwd_rise = fwd_q && !fwd_prev;
    assign rev_rise = rev_q && !rev_prev;

    // ----------------------------------------------------------------
    // Supply monitor
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] off_cnt;
    logic [CNT_W-1:0] next_off_cnt;
    logic power_lost;
    logic long_ret;
    logic inst_ret;
    logic restart_ok;
    logic alarm;
    logic next_alarm;

    // Counter saturates at the long-outage mark so it cannot wrap
    always_comb begin
        if (supply_ok) begin
            next_off_cnt = '0;
        end else if (off_cnt < CNT_W'(LONG_CYCLES)) begin
            next_off_cnt = off_cnt + CNT_W'(1);
        end else begin
            next_off_cnt = off_cnt;
        end
    end

    assign power_lost = !supply_ok && off_cnt >= CNT_W'(LOSS_CYCLES);
    assign long_ret = supply_ok && off_cnt >= CNT_W'(LONG_CYCLES);
    assign inst_ret = supply_ok && off_cnt >= CNT_W'(LOSS_CYCLES) && !long_ret;
    assign restart_ok = restart_coast_param <= RESTART_MAX;

    always_comb begin
        next_alarm = alarm;
        if (long_ret) begin
            next_alarm = 1'b0;
        end else if (inst_ret && !restart_ok) begin
            next_alarm = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Start latch and run request
    // ----------------------------------------------------------------
    drs_latch_type latch;
    drs_latch_type next_latch;
    logic run_req;
    logic run_rev;
    logic run_ok;
    logic [SPEED_W-1:0] run_target;

    always_comb begin
        next_latch = latch;
        if (shut_q || !three_wire || !hold_closed || long_ret) begin
            next_latch = LATCH_NONE;
        end else begin
            case (latch)
                LATCH_NONE: begin
                    if (fwd_q) begin
                        next_latch = LATCH_FWD;
                    end else if (rev_q) begin
                        next_latch = LATCH_REV;
                    end
                end
                LATCH_FWD: begin
                    if (rev_rise) begin
                        next_latch = LATCH_REV;
                    end
                end
                LATCH_REV: begin
                    if (fwd_rise) begin
                        next_latch = LATCH_FWD;
                    end
                end
                default: begin
                    next_latch = LATCH_NONE;
                end
            endcase
        end
    end

    always_comb begin
        if (three_wire) begin
            run_req = hold_closed && latch != LATCH_NONE;
            run_rev = latch == LATCH_REV;
        end else begin
            run_req = fwd_q ^ rev_q;
            run_rev = rev_q;
        end
        if (jog_q) begin
            run_ok = run_req;
            run_target = jog_speed_param;
        end else begin
            run_ok = run_req &&
                (speed_setpoint >= start_speed_param || min_speed_param != '0);
            run_target = (speed_setpoint > min_speed_param) ? speed_setpoint
                                                           : min_speed_param;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    drs_state_type state;
    drs_state_type next_state;
    logic force_off;
    logic at_brake;
    logic init_start;
    logic tmr_load;
    logic tmr_done;
    logic [CNT_W-1:0] tmr_value;

    assign force_off = power_lost || shut_q || alarm || (inst_ret && !restart_ok);
    assign at_brake = speed_command <= brake_speed_param;

    always_comb begin
        next_state = state;
        if (long_ret) begin
            next_state = ST_INIT;
        end else if (force_off) begin
            next_state = ST_OFF;
        end else begin
            case (state)
                ST_INIT: begin
                    if (tmr_done) begin
                        next_state = ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (run_ok) begin
                        next_state = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!run_ok) begin
                        next_state = ST_DECEL;
                    end
                end
                ST_DECEL: begin
                    if (run_ok) begin
                        next_state = ST_RUN;
                    end else if (at_brake) begin
                        next_state = (brake_time_param != '0) ? ST_BRAKE : ST_IDLE;
                    end
                end
                ST_BRAKE: begin
                    if (tmr_done) begin
                        next_state = ST_IDLE;
                    end
                end
                ST_OFF: begin
                    next_state = ST_IDLE;
                end
                default: begin
                    next_state = ST_INIT;
                end
            endcase
        end
    end

    // One timer serves the initial reset and the braking hold
    always_comb begin
        tmr_load = init_start || long_ret || (state != ST_BRAKE && next_state == ST_BRAKE);
        if (next_state == ST_BRAKE) begin
            tmr_value = CNT_W'(brake_time_param) * CNT_W'(BRAKE_UNIT_CYCLES);
        end else begin
            tmr_value = CNT_W'(INIT_CYCLES);
        end
    end

    drs_timer u_timer (
        .clock(clock),
        .rstn(rstn),
        .load(tmr_load),
        .value(tmr_value),
        .done(tmr_done)
    );

    // ----------------------------------------------------------------
    // Speed ramp and direction
    // ----------------------------------------------------------------
    logic [31:0] ramp_cnt;
    logic [31:0] next_ramp_cnt;
    logic [SPEED_W-1:0] next_speed;
    logic [SPEED_W-1:0] target;
    logic next_rev;
    logic ramp_step;

    always_comb begin
        // Two-wire reversal passes through zero speed; three-wire flips at speed
        if (state == ST_RUN && next_state == ST_RUN &&
            (three_wire || run_rev == reverse_polarity)) begin
            target = run_target;
        end else begin
            target = '0;
        end
        ramp_step = ramp_cnt >= 32'(accel_time_param) * 32'(RAMP_UNIT_CYC);
        next_ramp_cnt = ramp_step ? 32'h0 : ramp_cnt + 32'h1;
        next_speed = speed_command;
        if (next_state != ST_RUN && next_state != ST_DECEL) begin
            next_speed = '0;
        end else if (ramp_step && speed_command < target) begin
            next_speed = speed_command + SPEED_W'(1);
        end else if (ramp_step && speed_command > target) begin
            next_speed = speed_command - SPEED_W'(1);
        end
        next_rev = reverse_polarity;
        if (state == ST_IDLE && next_state == ST_RUN) begin
            next_rev = run_rev;
        end else if (state == ST_RUN && run_rev != reverse_polarity &&
                     (three_wire || speed_command == '0)) begin
            next_rev = run_rev;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            off_cnt <= '0;
            alarm <= 1'b0;
            latch <= LATCH_NONE;
            fwd_prev <= 1'b0;
            rev_prev <= 1'b0;
            state <= ST_INIT;
            init_start <= 1'b1;
            ramp_cnt <= 32'h0;
            speed_command <= '0;
            reverse_polarity <= 1'b0;
            output_enable <= 1'b0;
            dc_brake_active <= 1'b0;
            power_fail_alarm <= 1'b0;
            three_wire_active <= 1'b0;
        end else begin
            off_cnt <= next_off_cnt;
            alarm <= next_alarm;
            latch <= next_latch;
            fwd_prev <= fwd_q;
            rev_prev <= rev_q;
            state <= next_state;
            init_start <= 1'b0;
            ramp_cnt <= next_ramp_cnt;
            speed_command <= next_speed;
            reverse_polarity <= next_rev;
            output_enable <= next_state == ST_RUN || next_state == ST_DECEL ||
                             next_state == ST_BRAKE;
            dc_brake_active <= next_state == ST_BRAKE;
            power_fail_alarm <= next_alarm;
            three_wire_active <= three_wire;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_init_holds_off: assert property (
        state == ST_INIT && !tmr_done |=> !output_enable)
        else $error("output enabled during initial reset");
    a_loss_shuts_out: assert property (power_lost |=> !output_enable)
        else $error("output stayed on after supply loss");
    a_long_clears_trip: assert property (
        long_ret |=> !power_fail_alarm && state == ST_INIT)
        else $error("long outage did not reset the trip");
    a_inst_alarm_set: assert property (
        inst_ret && !restart_ok |=> power_fail_alarm ##1 power_fail_alarm)
        else $error("instantaneous failure without alarm");
    a_restart_no_alarm: assert property (
        inst_ret && restart_ok && !alarm |=> !power_fail_alarm)
        else $error("alarm raised although restart enabled");
    a_start_threshold: assert property (
        state == ST_IDLE && !jog_q && min_speed_param == '0 &&
        speed_setpoint < start_speed_param |=> !output_enable)
        else $error("started below start speed");
    a_brake_entry: assert property (
        $rose(dc_brake_active) |-> $past(speed_command) <= $past(brake_speed_param))
        else $error("braking began above brake speed");
    a_brake_skipped: assert property (
        brake_time_param == '0 |-> !dc_brake_active ##1 !dc_brake_active)
        else $error("braking with zero brake time");
    a_both_inputs_stop: assert property (
        !three_wire && !jog_q && fwd_q && rev_q && state == ST_RUN |=> state != ST_RUN)
        else $error("both direction inputs did not stop");
    a_hold_open_clear: assert property (
        three_wire && !hold_closed |=> latch == LATCH_NONE)
        else $error("latch kept with hold open");
    a_direct_reverse: assert property (
        three_wire && hold_closed && latch == LATCH_FWD && rev_rise && state == ST_RUN &&
        !force_off && !long_ret && run_ok |=> latch == LATCH_REV)
        else $error("opposite input did not reverse latch");
    a_shutoff_latch: assert property (shut_q |=> latch == LATCH_NONE)
        else $error("shutoff did not clear latch");
    a_shutoff_output: assert property (shut_q |=> !output_enable)
        else $error("shutoff did not cut output");

    c_run: cover property (state == ST_IDLE ##1 state == ST_RUN);
    c_brake: cover property (state == ST_DECEL ##1 state == ST_BRAKE);
    c_reverse: cover property (state == ST_RUN && $changed(reverse_polarity));
    c_alarm: cover property ($rose(power_fail_alarm));
endmodule

// ==== drs_switches.sv ====
// Switch panel model that drives the contact inputs of the drive
`timescale 1ns/1ps
module drs_switches
    import drs_pkg::*;
(
    input wire logic clock,
    input wire logic want_fwd,
    input wire logic want_rev,
    input wire logic want_shut,
    input wire logic [N_ASSIGN-1:0] want_asg,
    input wire logic chatter,
    output logic fwd = 1'b0,
    output logic rev = 1'b0,
    output logic shut = 1'b0,
    output logic [N_ASSIGN-1:0] asg = '0
);
    // Runs and stops only through contacts; chatter mimics a bouncing forward switch
    always @(posedge clock) begin
        fwd <= chatter ? ~fwd : want_fwd;
        rev <= want_rev;
        shut <= want_shut;
        asg <= want_asg;
    end
endmodule

// ==== drs_run_stop_tb.sv ====
// Self-checking testbench for the run/stop and power sequencing block
`timescale 1ns/1ps
module drs_run_stop_tb;
    import drs_pkg::*;
    localparam int OE = 0, RP = 1, DB = 2, PF = 3, TW = 4;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic want_fwd = 1'b1, want_rev = 1'b0, want_shut = 1'b0, chatter = 1'b0, supply_ok = 1'b1;
    logic [N_ASSIGN-1:0] want_asg = '0, asg;
    logic fwd, rev, shut, brake_seen = 1'b0;
    logic [SPEED_W-1:0] setpoint = 16'h0064, min_speed = 16'h0000, speed_command;
    logic [SPEED_W-1:0] start_speed = 16'h000f, jog_speed = 16'h001e, brake_speed = 16'h0005;
    logic [15:0] brake_time = 16'h0002, restart_coast = 16'h0033, accel = 16'h0000;
    logic [MAP_W-1:0] tmap = 12'h000;
    logic output_enable, reverse_polarity, dc_brake_active, power_fail_alarm, three_wire_active;
    int errors = 0, comparisons = 0;

    always #12.5 clock = ~clock;
    always @(posedge clock) if (dc_brake_active === 1'b1) brake_seen <= 1'b1;

    drs_switches i_sw (.clock(clock), .want_fwd(want_fwd), .want_rev(want_rev),
        .want_shut(want_shut), .want_asg(want_asg), .chatter(chatter), .fwd(fwd), .rev(rev),
        .shut(shut), .asg(asg));

    // Short counts keep the run brief
    drs_run_stop #(.INIT_CYCLES(50), .LOSS_CYCLES(20), .LONG_CYCLES(100),
        .BRAKE_UNIT_CYCLES(10), .DEBOUNCE_CYCLES(4)) i_dut (.clock(clock), .rstn(rstn),
        .forward_start_input(fwd), .reverse_start_input(rev), .output_shutoff_input(shut),
        .assignable_input(asg), .supply_ok(supply_ok), .speed_setpoint(setpoint),
        .start_speed_param(start_speed), .min_speed_param(min_speed), .jog_speed_param(jog_speed),
        .accel_time_param(accel), .brake_speed_param(brake_speed), .brake_time_param(brake_time),
        .restart_coast_param(restart_coast), .terminal_assign_param(tmap),
        .output_enable(output_enable), .reverse_polarity(reverse_polarity),
        .speed_command(speed_command), .dc_brake_active(dc_brake_active),
        .power_fail_alarm(power_fail_alarm), .three_wire_active(three_wire_active));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic out_bit(input int k);
        case (k)
            OE: return output_enable;
            RP: return reverse_polarity;
            DB: return dc_brake_active;
            PF: return power_fail_alarm;
            default: return three_wire_active;
        endcase
    endfunction

    task automatic check(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            errors++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask

    task automatic wait_bit(input int k, input logic v, input int n, input string msg);
        int i;
        i = 0;
        while (out_bit(k) !== v && i < n) begin
            @(posedge clock);
            #1;
            i++;
        end
        check(out_bit(k) === v, msg);
    endtask

    task automatic hold_bit(input int k, input logic v, input int n, input string msg);
        logic ok;
        ok = 1'b1;
        repeat (n) begin
            @(posedge clock);
            #1;
            if (out_bit(k) !== v) ok = 1'b0;
        end
        check(ok, msg);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_init();
        hold_bit(OE, 1'b0, 40, "ran during initial reset");
        wait_bit(OE, 1'b1, 30, "no start after initial reset");
        check(reverse_polarity === 1'b0 && three_wire_active === 1'b0, "fwd two-wire");
    endtask

    task automatic t_two_wire();
        cycles(1);
        want_fwd <= 1'b0;
        wait_bit(DB, 1'b1, 200, "release gave no brake");
        check(speed_command === 16'h0000, "speed not zero in brake");
        hold_bit(DB, 1'b1, 15, "brake too short");
        wait_bit(OE, 1'b0, 15, "brake did not end");
        want_rev <= 1'b1;
        wait_bit(OE, 1'b1, 30, "reverse did not run");
        check(reverse_polarity === 1'b1, "wrong direction");
        want_fwd <= 1'b1;
        wait_bit(DB, 1'b1, 200, "both closed did not stop");
        want_fwd <= 1'b0;
        want_rev <= 1'b0;
        wait_bit(OE, 1'b0, 40, "no stop after both");
        brake_time <= 16'h0000;
        want_fwd <= 1'b1;
        wait_bit(OE, 1'b1, 30, "no restart");
        brake_seen <= 1'b0;
        want_fwd <= 1'b0;
        wait_bit(OE, 1'b0, 250, "no stop");
        check(brake_seen === 1'b0, "brake with zero time");
    endtask

    task automatic t_speed();
        setpoint <= 16'h000a;
        want_fwd <= 1'b1;
        hold_bit(OE, 1'b0, 40, "ran below start speed");
        min_speed <= 16'h0014;
        wait_bit(OE, 1'b1, 30, "minimum speed no start");
        cycles(40);
        #1;
        check(speed_command === 16'h0014, "not at minimum speed");
        want_fwd <= 1'b0;
        min_speed <= 16'h0000;
        setpoint <= 16'h0064;
        wait_bit(OE, 1'b0, 60, "no stop");
    endtask

    task automatic t_three_wire();
        tmap <= 12'h536;
        brake_time <= 16'h0001;
        wait_bit(TW, 1'b1, 5, "hold mapping ignored");
        want_asg <= 3'b001;
        cycles(12);
        want_fwd <= 1'b1;
        cycles(12);
        want_fwd <= 1'b0;
        wait_bit(OE, 1'b1, 30, "latched start missing");
        hold_bit(OE, 1'b1, 40, "start not held");
        check(reverse_polarity === 1'b0, "first input lost");
        brake_seen <= 1'b0;
        want_rev <= 1'b1;
        cycles(12);
        want_rev <= 1'b0;
        wait_bit(RP, 1'b1, 20, "no reversal");
        check(output_enable === 1'b1 && brake_seen === 1'b0, "stopped on reverse");
        want_asg <= 3'b000;
        cycles(12);
        want_asg <= 3'b001;
        wait_bit(OE, 1'b0, 250, "hold open did not stop");
        hold_bit(OE, 1'b0, 30, "latch survived hold");
        want_fwd <= 1'b1;
        cycles(12);
        want_fwd <= 1'b0;
        wait_bit(OE, 1'b1, 30, "no second start");
        want_asg <= 3'b101;
        wait_bit(OE, 1'b0, 12, "shutoff slow");
        want_asg <= 3'b001;
        hold_bit(OE, 1'b0, 30, "latch survived shutoff");
        want_asg <= 3'b010;
        wait_bit(TW, 1'b0, 15, "jog did not override hold");
        want_fwd <= 1'b1;
        wait_bit(OE, 1'b1, 30, "jog did not run");
        want_fwd <= 1'b0;
        wait_bit(OE, 1'b0, 90, "jog no stop");
        want_asg <= 3'b000;
        tmap <= 12'h000;
    endtask

    task automatic t_power();
        want_fwd <= 1'b1;
        wait_bit(OE, 1'b1, 30, "no run");
        supply_ok <= 1'b0;
        wait_bit(OE, 1'b0, 25, "output kept on loss");
        cycles(10);
        supply_ok <= 1'b1;
        wait_bit(PF, 1'b1, 5, "no alarm");
        hold_bit(OE, 1'b0, 30, "ran with alarm");
        supply_ok <= 1'b0;
        cycles(120);
        supply_ok <= 1'b1;
        wait_bit(PF, 1'b0, 5, "alarm not cleared");
        wait_bit(OE, 1'b1, 90, "no resume");
        restart_coast <= 16'h0032;
        supply_ok <= 1'b0;
        cycles(30);
        supply_ok <= 1'b1;
        hold_bit(PF, 1'b0, 5, "alarm with restart");
        wait_bit(OE, 1'b1, 30, "no auto restart");
        supply_ok <= 1'b0;
        hold_bit(OE, 1'b1, 10, "short dip cut output");
        supply_ok <= 1'b1;
        want_fwd <= 1'b0;
        wait_bit(OE, 1'b0, 250, "no stop");
    endtask

    task automatic t_chatter();
        chatter <= 1'b1;
        hold_bit(OE, 1'b0, 40, "bounce started drive");
        chatter <= 1'b0;
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        errors++;
        report_and_stop();
    end

    initial begin
        cycles(8);
        rstn <= 1'b1;
        t_init();
        t_two_wire();
        t_speed();
        t_three_wire();
        t_power();
        t_chatter();
        report_and_stop();
    end
endmodule
